// ---- shared/vbi_capture_pkg.sv ----
// Constants shared by the VBI data capture register block
package vbi_capture_pkg;

    // Register sub-addresses
    localparam logic [7:0] ADDR_CAPTURE_REQUEST = 8'h0A;
    localparam logic [7:0] ADDR_STATUS_FLAGS    = 8'h10;
    localparam logic [7:0] ADDR_CAPTION_LOW     = 8'h12;
    localparam logic [7:0] ADDR_CAPTION_HIGH    = 8'h13;
    localparam logic [7:0] ADDR_EXTENDED_LOW    = 8'h14;
    localparam logic [7:0] ADDR_EXTENDED_HIGH   = 8'h15;
    localparam logic [7:0] ADDR_COPY_UPPER      = 8'h16;
    localparam logic [7:0] ADDR_COPY_LOWER      = 8'h17;

    // Request bit positions
    localparam int REQ_CAPTION_BIT   = 0;
    localparam int REQ_EXTENDED_BIT  = 1;
    localparam int REQ_COPY_INFO_BIT = 2;

    // Status bit positions
    localparam int STS_CAPTION_BIT   = 5;
    localparam int STS_EXTENDED_BIT  = 6;
    localparam int STS_COPY_INFO_BIT = 7;

    // Values after reset
    localparam logic       DONE_FLAG_RESET = 1'b1;
    localparam logic [7:0] DATA_REG_RESET  = 8'h00;

    // Active video ranges, 525-line system
    localparam logic [9:0] NTSC_ACT1_FIRST = 10'd22;
    localparam logic [9:0] NTSC_ACT1_LAST  = 10'd261;
    localparam logic [9:0] NTSC_ACT2_FIRST = 10'd285;
    localparam logic [9:0] NTSC_ACT2_LAST  = 10'd524;

    // Active video ranges, 625-line system
    localparam logic [9:0] PAL_ACT1_FIRST = 10'd23;
    localparam logic [9:0] PAL_ACT1_LAST  = 10'd310;
    localparam logic [9:0] PAL_ACT2_FIRST = 10'd336;
    localparam logic [9:0] PAL_ACT2_LAST  = 10'd623;

    // Data-bearing lines
    localparam logic [9:0] LINE_CAPTION    = 10'd21;
    localparam logic [9:0] LINE_EXTENDED   = 10'd284;
    localparam logic [9:0] LINE_VBID_ODD   = 10'd20;
    localparam logic [9:0] LINE_VBID_EVEN  = 10'd283;
    localparam logic [9:0] LINE_WSS        = 10'd23;

    // Black level sent during blanking
    localparam logic [7:0] BLACK_LUMA   = 8'h10;
    localparam logic [7:0] BLACK_CHROMA = 8'h80;

    // Copy-management word check: x^6 + x + 1, preset to all ones
    localparam logic [5:0] VBID_CRC_PRESET = 6'h3F;
    localparam int         VBID_DATA_BITS  = 14;
    localparam int         VBID_CRC_BITS   = 6;

endpackage

// ---- verilog/vbi_data_capture_regs.sv ----
// VBI data capture registers: request, completion flags and decoded data
`timescale 1ns/1ps
`default_nettype none

// How it works
//
// Three capture kinds share one pattern:
// a pending bit, a done flag and a data store.
// Caption, extended caption and copy info
// each run on their own, never waiting on
// one another.

// Arming
//
// A write to the request register with a bit
// set arms that kind of capture.
// The pending bit rises at the next edge.
// The done flag falls at that same edge.
// Zero bits in the write change nothing.
// Reserved upper bits are simply dropped.

// Re-arming
//
// Writing a request that is already pending
// keeps it pending and keeps the flag low.
// Nothing is queued: one request gives
// at most one capture.

// Capture
//
// The slicer outside this block gives one
// pulse per line with the sliced bits.
// A pulse is used only when its kind is
// pending and the line number matches.
// Any other pulse is ignored outright.
// That keeps a stale line from overwriting
// data the host has not read yet.

// Commit
//
// On a valid pulse the data store loads and
// the flag rises at the very same edge.
// The host can never see a set flag while
// the store still holds older bytes.
// The pending bit drops at that edge too.

// Collision
//
// A pulse and a new request can land in one
// cycle. The flag then reads one, and the new
// request stays armed for the next line.
// Losing the captured data was judged worse
// than one extra capture.

// Flags after reset
//
// All three flags come up set, so a poller
// that starts before any request sees
// nothing outstanding.
// Pending bits come up clear.

// Data after reset
//
// Every data store reads zero after reset.
// Software should not trust a store before
// its first completed capture.

// Line systems
//
// A single level input says whether the
// source is a 525 or a 625 line system.
// Caption, extended caption and copy
// management only exist on 525 lines.
// Widescreen signalling only exists on 625.
// Lines of the wrong system never commit.

// Line numbers
//
// Line numbers are one based and come from
// the decoder's own line counter.
// This block does not count lines itself,
// so it follows whatever that counter says.

// Copy management word
//
// The sliced copy word arrives first bit
// highest, with six check bits below it.
// The check code is recomputed here over
// all fourteen data bits and compared.
// Only thirteen data bits are stored; the
// last slot keeps the check result instead.
// A one there means the code matched.

// Check code
//
// The generator is x^6 + x + 1, preset to
// all ones, fed first bit first.
// The loop unrolls into a small xor tree;
// it sits on the slicer pulse path only.

// Widescreen word
//
// On 625 lines the shared store takes the
// fourteen widescreen bits as they stand.
// No check is applied to them.

// Shared store
//
// Copy management and widescreen results
// use one register pair. A capture of either
// kind replaces what the other left there.
// Software must know the line system when
// it interprets the pair.

// Reading
//
// Reads are combinational from the address.
// Reserved bits and unmapped addresses read
// zero, as does the write-only request
// register.
// Reading never clears or changes anything.

// Status register
//
// The three flags fill the top bits of the
// shared status byte. The low five bits are
// other decoder status passed through.
// Writes to the status byte are ignored.

// Pixel path
//
// Pixels pass through one register stage.
// Lines outside the active window are
// replaced by black: luma sixteen and both
// chroma codes at mid-scale.
// The window depends on the line system.
// A flag output marks lines let through.

// Latency
//
// Pixel output lags its input by one clock.
// Register writes take effect at the next
// edge, and a commit is visible one edge
// after its slicer pulse.

// Limitations
//
// No timeout: a request on a system that
// never carries its line stays pending.
// Black forcing has no enable bit here.
// No interrupt is raised; software polls.


module vbi_data_capture_regs
    import vbi_capture_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,

    // Register access from the serial control core
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,

    // Line timing from the decoder core
    input  wire logic        system_625,
    input  wire logic [9:0]  line_number,

    // Sliced VBI bits, one pulse at the end of a line
    input  wire logic        slice_valid,
    input  wire logic [19:0] slice_bits,

    // Other status bits of the shared status register
    input  wire logic [4:0]  other_status,

    // Pixel stream in and out
    input  wire logic [7:0]  luma_in,
    input  wire logic [7:0]  cb_in,
    input  wire logic [7:0]  cr_in,
    output logic      [7:0]  luma_out,
    output logic      [7:0]  cb_out,
    output logic      [7:0]  cr_out,
    output logic             active_line
);

    // Check code over copy-management bits, first bit shifted in first
    function automatic logic [5:0] vbid_crc(input logic [13:0] bits);
        logic [5:0] crc;
        logic       fb;
        crc = VBID_CRC_PRESET;
        for (int i = VBID_DATA_BITS - 1; i >= 0; i--) begin
            fb  = crc[5] ^ bits[i];
            crc = {crc[4:0], 1'b0} ^ {4'b0000, fb, fb};
        end
        return crc;
    endfunction

    // Range test used for both line systems
    function automatic logic in_range(input logic [9:0] n,
                                      input logic [9:0] lo,
                                      input logic [9:0] hi);
        return (n >= lo) && (n <= hi);
    endfunction

    logic        caption_pending_q,  caption_pending_d;
    logic        extended_pending_q, extended_pending_d;
    logic        copy_pending_q,     copy_pending_d;
    logic        caption_done_flag_q,   caption_done_flag_d;
    logic        extended_done_flag_q,  extended_done_flag_d;
    logic        copy_info_done_flag_q, copy_info_done_flag_d;
    logic [15:0] caption_word_q;
    logic [15:0] extended_word_q;
    logic [13:0] copy_info_q;
    logic [13:0] copy_info_d;

    // Active line decode
    wire ntsc_active = in_range(line_number, NTSC_ACT1_FIRST, NTSC_ACT1_LAST)
                     | in_range(line_number, NTSC_ACT2_FIRST, NTSC_ACT2_LAST);
    wire pal_active  = in_range(line_number, PAL_ACT1_FIRST, PAL_ACT1_LAST)
                     | in_range(line_number, PAL_ACT2_FIRST, PAL_ACT2_LAST);
    wire line_active = system_625 ? pal_active : ntsc_active;

    // Request decode; a zero in a bit leaves that capture alone
    wire req_wr        = reg_wr && (reg_addr == ADDR_CAPTURE_REQUEST);
    wire caption_req   = req_wr && reg_wdata[REQ_CAPTION_BIT];
    wire extended_req  = req_wr && reg_wdata[REQ_EXTENDED_BIT];
    wire copy_info_req = req_wr && reg_wdata[REQ_COPY_INFO_BIT];

    // Which line is carrying which data
    wire on_caption_line  = !system_625 && (line_number == LINE_CAPTION);
    wire on_extended_line = !system_625 && (line_number == LINE_EXTENDED);
    wire on_vbid_line     = !system_625 && ((line_number == LINE_VBID_ODD)
                                         || (line_number == LINE_VBID_EVEN));
    wire on_wss_line      = system_625 && (line_number == LINE_WSS);

    // Commit strobes: only a pending request consumes a sliced line
    wire caption_commit  = slice_valid && caption_pending_q && on_caption_line;
    wire extended_commit = slice_valid && extended_pending_q && on_extended_line;
    wire copy_commit     = slice_valid && copy_pending_q
                         && (on_vbid_line || on_wss_line);

    // Copy-management bits arrive first-bit-high with the check code below them
    wire [13:0] vbid_payload = slice_bits[19:6];
    wire [5:0]  vbid_check   = slice_bits[5:0];
    wire        vbid_crc_ok  = (vbid_crc(vbid_payload) == vbid_check);

    // Shared storage layout: on 525 lines 13 data bits then the check result in the last slot; on 625 lines all 14 widescreen bits
    always_comb begin
        if (system_625) begin
            copy_info_d = slice_bits[13:0];
        end else begin
            copy_info_d = {vbid_payload[13:1], vbid_crc_ok};
        end
    end

    // Pending and flag next state; a decode landing with a new request still sets the flag
    always_comb begin
        caption_pending_d     = caption_req   | (caption_pending_q  & ~caption_commit);
        extended_pending_d    = extended_req  | (extended_pending_q & ~extended_commit);
        copy_pending_d        = copy_info_req | (copy_pending_q     & ~copy_commit);
        caption_done_flag_d   = caption_commit  ? 1'b1 :
                                (caption_req ? 1'b0 : caption_done_flag_q);
        extended_done_flag_d  = extended_commit ? 1'b1 :
                                (extended_req ? 1'b0 : extended_done_flag_q);
        copy_info_done_flag_d = copy_commit ? 1'b1 :
                                (copy_info_req ? 1'b0 : copy_info_done_flag_q);
    end

    // Request and completion state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            caption_pending_q     <= 1'b0;
            extended_pending_q    <= 1'b0;
            copy_pending_q        <= 1'b0;
            caption_done_flag_q   <= DONE_FLAG_RESET;
            extended_done_flag_q  <= DONE_FLAG_RESET;
            copy_info_done_flag_q <= DONE_FLAG_RESET;
        end else begin
            caption_pending_q     <= caption_pending_d;
            extended_pending_q    <= extended_pending_d;
            copy_pending_q        <= copy_pending_d;
            caption_done_flag_q   <= caption_done_flag_d;
            extended_done_flag_q  <= extended_done_flag_d;
            copy_info_done_flag_q <= copy_info_done_flag_d;
        end
    end

    // Decoded data; loads only on its own commit so old data is kept
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            caption_word_q  <= {DATA_REG_RESET, DATA_REG_RESET};
            extended_word_q <= {DATA_REG_RESET, DATA_REG_RESET};
            copy_info_q     <= {DATA_REG_RESET[5:0], DATA_REG_RESET};
        end else begin
            if (caption_commit) begin
                caption_word_q <= slice_bits[15:0];
            end
            if (extended_commit) begin
                extended_word_q <= slice_bits[15:0];
            end
            if (copy_commit) begin
                copy_info_q <= copy_info_d;
            end
        end
    end

    // Status register image
    wire [7:0] status_image = {copy_info_done_flag_q, extended_done_flag_q,
                               caption_done_flag_q, other_status};

    // Read mux; request register is write-only and reads zero like unmapped addresses
    always_comb begin
        unique case (reg_addr)
            ADDR_STATUS_FLAGS:  reg_rdata = status_image;
            ADDR_CAPTION_LOW:   reg_rdata = caption_word_q[7:0];
            ADDR_CAPTION_HIGH:  reg_rdata = caption_word_q[15:8];
            ADDR_EXTENDED_LOW:  reg_rdata = extended_word_q[7:0];
            ADDR_EXTENDED_HIGH: reg_rdata = extended_word_q[15:8];
            ADDR_COPY_UPPER:    reg_rdata = {2'b00, copy_info_q[13:8]};
            ADDR_COPY_LOWER:    reg_rdata = copy_info_q[7:0];
            default:            reg_rdata = 8'h00;
        endcase
    end

    // Pixel output; blanking lines are forced to black one cycle later
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            luma_out    <= BLACK_LUMA;
            cb_out      <= BLACK_CHROMA;
            cr_out      <= BLACK_CHROMA;
            active_line <= 1'b0;
        end else begin
            luma_out    <= line_active ? luma_in : BLACK_LUMA;
            cb_out      <= line_active ? cb_in   : BLACK_CHROMA;
            cr_out      <= line_active ? cr_in   : BLACK_CHROMA;
            active_line <= line_active;
        end
    end

endmodule

`default_nettype wire

// ---- verif/vbi_capture_assertions.sv ----
// Port-level checks for the VBI capture register block
`timescale 1ns/1ps
`default_nettype none
module vbi_capture_checker
    import vbi_capture_pkg::*;
(
    // Clock, reset and register port
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [4:0] other_status,
    // Line timing and pixels
    input wire logic       system_625,
    input wire logic [9:0] line_number,
    input wire logic       slice_valid,
    input wire logic [7:0] luma_in,
    input wire logic [7:0] luma_out,
    input wire logic [7:0] cb_out,
    input wire logic       active_line
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Active window recomputed here, so a slip in the design's range test cannot hide
    wire logic act = system_625 ?
        (line_number inside {[PAL_ACT1_FIRST:PAL_ACT1_LAST], [PAL_ACT2_FIRST:PAL_ACT2_LAST]}) :
        (line_number inside {[NTSC_ACT1_FIRST:NTSC_ACT1_LAST], [NTSC_ACT2_FIRST:NTSC_ACT2_LAST]});
    wire logic sts = reg_addr == ADDR_STATUS_FLAGS;
    // A flag reading zero means its request is still pending
    a_copy_req_clear: assert property ((reg_wr && reg_addr == ADDR_CAPTURE_REQUEST
        && reg_wdata[2] && !slice_valid) ##1 sts |-> !reg_rdata[7]) else $error("copy flag kept");
    a_caption_sets_flag: assert property ((sts && !reg_rdata[5] && slice_valid
        && !system_625 && line_number == LINE_CAPTION) |=> (!sts || reg_rdata[5]))
        else $error("caption flag not set");
    a_caption_line_only: assert property ((sts && !reg_rdata[5] && slice_valid
        && (system_625 || line_number != LINE_CAPTION)) |=> (!sts || !reg_rdata[5]))
        else $error("caption taken from wrong line");
    a_caption_data_hold: assert property ((reg_addr == ADDR_CAPTION_LOW && slice_valid
        && line_number != LINE_CAPTION) |=> (reg_addr != ADDR_CAPTION_LOW || $stable(reg_rdata)))
        else $error("caption data changed");
    a_request_reads_zero: assert property (reg_addr == ADDR_CAPTURE_REQUEST |-> reg_rdata == 8'h00)
        else $error("request register readable");
    a_status_low_bits: assert property (sts |-> reg_rdata[4:0] == other_status)
        else $error("status low bits wrong");
    a_active_passes: assert property (act |=> active_line && luma_out == $past(luma_in))
        else $error("active line not passed");
    a_blank_black: assert property (!act |=> !active_line && luma_out == BLACK_LUMA
        && cb_out == BLACK_CHROMA) else $error("blank line not black");
    // Main scenarios
    cover property (sts && slice_valid && !system_625 && line_number == LINE_CAPTION);
    cover property (slice_valid && system_625 && line_number == LINE_WSS);
    cover property (!act ##1 act);
endmodule
`default_nettype wire

// ---- verif/vbi_line_source.sv ----
// Video source model: line timing and sliced VBI bits
`timescale 1ns/1ps
`default_nettype none
module vbi_line_source (
    // Clock
    input  wire logic        clk,
    // Toward the capture block
    output var  logic        system_625,
    output var  logic [9:0]  line_number,
    output var  logic        slice_valid,
    output var  logic [19:0] slice_bits
);
    // Idle on a blanking line with no pulse
    initial {system_625, line_number, slice_valid, slice_bits} = {11'h001, 1'b0, 20'h0F0F0};
    // One line; the pulse lasts one cycle, then the bits turn over so stale data looks wrong
    task automatic send(input logic s, input logic [9:0] n, input logic [19:0] b, input logic p);
        {system_625, line_number, slice_bits, slice_valid} = {s, n, b, p};
        @(posedge clk) #1 {slice_valid, slice_bits} = {1'b0, ~b};
        // Let one edge pass so a following line never re-drives in this time step
        @(posedge clk) #1;
    endtask
endmodule
`default_nettype wire

// ---- verif/vbi_data_capture_regs_test.sv ----
// Self-checking bench for the VBI capture register block
`timescale 1ns/1ps
`default_nettype none
module vbi_data_capture_regs_test;
    import vbi_capture_pkg::*;
    logic        clk, arst_n, reg_wr, system_625, slice_valid, active_line, act_e;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, luma_out, cb_out, cr_out;
    logic [9:0]  line_number;
    logic [13:0] d14;
    logic [19:0] slice_bits;
    int          n_errors, total_checks, k;
    logic [10:0] bad [6] = '{11'h415, 11'h016, 11'h51C, 11'h11D, 11'h017, 11'h414};
    logic [9:0]  edges [16] = '{10'h015, 10'h016, 10'h105, 10'h106, 10'h11C, 10'h11D, 10'h20C,
        10'h20D, 10'h016, 10'h017, 10'h136, 10'h137, 10'h14F, 10'h150, 10'h26F, 10'h270};
    // Pixel inputs are constants; the pass-through check still sees them
    vbi_data_capture_regs vbi_data_capture_regs_inst (.clk(clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .system_625(system_625), .line_number(line_number), .slice_valid(slice_valid),
        .slice_bits(slice_bits), .other_status(5'h15), .luma_in(8'h5A), .cb_in(8'h3C),
        .cr_in(8'hC3), .luma_out(luma_out), .cb_out(cb_out), .cr_out(cr_out),
        .active_line(active_line));
    vbi_line_source vbi_line_source_inst (.clk(clk), .system_625(system_625),
        .line_number(line_number), .slice_valid(slice_valid), .slice_bits(slice_bits));
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Every task starts and ends just after a rising edge
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(posedge clk) #1 reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        #1 chk(reg_rdata, e);
        @(posedge clk) #1;
    endtask
    function automatic logic [5:0] crc6(input logic [13:0] d);
        logic [5:0] c = VBID_CRC_PRESET;
        for (int i = 13; i >= 0; i--) c = {c[4:0], 1'b0} ^ {4'h0, {2{c[5] ^ d[i]}}};
        return c;
    endfunction
    task automatic complete_run();
        if (n_errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        {arst_n, reg_wr, reg_addr, reg_wdata, n_errors, total_checks} = '0;
        repeat (6) @(posedge clk);
        #1 arst_n = 1'b1;
        // Reset state, an unmapped place and refused writes
        rd(ADDR_STATUS_FLAGS, 8'hF5);
        for (k = 0; k < 7; k++) rd(ADDR_CAPTION_LOW + 8'(k), 8'h00);
        wr(ADDR_STATUS_FLAGS, 8'h00);
        @(posedge clk) #1;
        wr(ADDR_CAPTURE_REQUEST, 8'hF8);
        rd(ADDR_STATUS_FLAGS, 8'hF5);
        // Arm caption, then after one idle cycle the other two, then feed lines that must be ignored
        wr(ADDR_CAPTURE_REQUEST, 8'h01);
        @(posedge clk) #1;
        wr(ADDR_CAPTURE_REQUEST, 8'h06);
        rd(ADDR_STATUS_FLAGS, 8'h15);
        for (k = 0; k < 6; k++) vbi_line_source_inst.send(bad[k][10], bad[k][9:0], 20'hABCDE, 1'b1);
        rd(ADDR_STATUS_FLAGS, 8'h15);
        // Caption, then a second caption line with no request, then extended and widescreen
        vbi_line_source_inst.send(1'b0, LINE_CAPTION, 20'h3ABCD, 1'b1);
        rd(ADDR_STATUS_FLAGS, 8'h35);
        wr(ADDR_CAPTURE_REQUEST, 8'h00);
        vbi_line_source_inst.send(1'b0, LINE_CAPTION, 20'h01111, 1'b1);
        rd(ADDR_CAPTION_LOW, 8'hCD);
        vbi_line_source_inst.send(1'b0, LINE_EXTENDED, 20'h51234, 1'b1);
        rd(ADDR_CAPTION_HIGH, 8'hAB);
        rd(ADDR_STATUS_FLAGS, 8'h75);
        rd(ADDR_EXTENDED_LOW, 8'h34);
        rd(ADDR_EXTENDED_HIGH, 8'h12);
        vbi_line_source_inst.send(1'b1, LINE_WSS, 20'hF2A5C, 1'b1);
        rd(ADDR_STATUS_FLAGS, 8'hF5);
        rd(ADDR_COPY_UPPER, 8'h2A);
        rd(ADDR_COPY_LOWER, 8'h5C);
        // Copy management on both lines, good check code first, then a spoiled one
        for (k = 0; k < 2; k++) begin
            d14 = k ? 14'h135B : 14'h2D36;
            wr(ADDR_CAPTURE_REQUEST, 8'h04);
            rd(ADDR_STATUS_FLAGS, 8'h75);
            vbi_line_source_inst.send(1'b0, k ? LINE_VBID_EVEN : LINE_VBID_ODD,
                {d14, crc6(d14) ^ 6'(k)}, 1'b1);
            rd(ADDR_COPY_UPPER, {2'b00, d14[13:8]});
            rd(ADDR_COPY_LOWER, {d14[7:1], k == 0});
        end
        // Window edges of both systems: pass-through when active, black otherwise
        for (k = 0; k < 16; k++) begin
            act_e = (k % 4 == 1) || (k % 4 == 2);
            vbi_line_source_inst.send(k > 7, edges[k], 20'h00000, 1'b0);
            chk({7'h00, active_line}, {7'h00, act_e});
            chk(cr_out, act_e ? 8'hC3 : BLACK_CHROMA);
        end
        complete_run();
    end
endmodule
bind vbi_data_capture_regs vbi_capture_checker vbi_capture_checker_inst (.clk(clk),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .other_status(other_status), .system_625(system_625),
    .line_number(line_number), .slice_valid(slice_valid), .luma_in(luma_in),
    .luma_out(luma_out), .cb_out(cb_out), .active_line(active_line));
`default_nettype wire
